// File: include/fp_compare_map.vh
// Purpose: constants for the fp compare ge/eq-flags datapath
// Assumes: 32-bit operands, single-precision IEEE encoding
// Notes: flag bit layout follows the status-word exception bits
// Contract
// - The equality flag query decodes from opcode 149, takes two operands, answers in 1 cycle, slot 3.
// - The greater-or-equal compare decodes from opcode 146, takes two operands, answers in 1 cycle.
// - The equality flag query returns the bit vector of exceptions an equality compare would raise.
// - The equality flag query never changes the status-word exception flags.
// - A denormal operand of the equality flag query is taken as zero and sets bit 0x20 in the result.
// - The guarded equality flag query writes its destination only when the guard lsb is 1.
// - The equality flag query with a quiet NaN and a number returns zero flags.
// - The greater-or-equal compare writes 1 when the first operand is >= the second, else 0.
// - A denormal operand of the greater-or-equal compare is taken as zero and sets the flushed flag.
// - Exceptions raised by the greater-or-equal compare set their status-word flags.
// - Status-word exception flags are sticky and only an explicit status-word write clears them.
// - The greater-or-equal compare updates the flags in the same cycle as its destination write.
// - Simultaneous flag updates OR together with the existing flag value.
// - A guard lsb of 0 on the greater-or-equal compare blocks both destination and flag update.
// - The greater-or-equal compare with a quiet NaN returns 0 and raises invalid operation.
`ifndef FP_COMPARE_MAP_VH
`define FP_COMPARE_MAP_VH
`define OPC_EQL_FLAGS 8'h95
`define OPC_GEQ 8'h92
`define ISSUE_SLOT_EQL_FLAGS 3'h3
`define FLAG_W 6
`define FLAG_FLUSHED 5
`define FLAG_INVALID 4
`define FLAG_FLUSHED_VAL 6'h20
`define FLAG_INVALID_VAL 6'h10
`define FLAGS_RESET 6'h00
`define DEST_RESET 32'h00000000
`define DEST_INDEX_RESET 5'h0
`endif

// File: verilog/fp_cmp_core.v
// Purpose: combinational single-precision compare core
// Assumes: denormals flushed to zero before compare
// Notes: yields ge, eq and the exception flags each op would raise
`timescale 1ns/100ps
`include "fp_compare_map.vh"
module fp_cmp_core (
  input wire [31:0] op_a,
  input wire [31:0] op_b,
  output reg ge,
  output reg eq_flags_any,
  output reg [`FLAG_W-1:0] eq_flags,
  output reg [`FLAG_W-1:0] ge_flags
);
  // ************************************************************
  // operand classification
  // ************************************************************
  function is_denorm;
    input [31:0] v;
    begin
      is_denorm = (v[30:23] == 8'h00) && (v[22:0] != 23'h0);
    end
  endfunction
  function is_nan;
    input [31:0] v;
    begin
      is_nan = (v[30:23] == 8'hff) && (v[22:0] != 23'h0);
    end
  endfunction
  function is_snan;
    input [31:0] v;
    begin
      is_snan = is_nan(v) && !v[22];
    end
  endfunction
  function [31:0] flush;
    input [31:0] v;
    begin
      flush = is_denorm(v) ? {v[31], 31'h0} : v;
    end
  endfunction
  // ************************************************************
  // compare
  // ************************************************************
  reg [31:0] fa;
  reg [31:0] fb;
  reg a_zero;
  reg b_zero;
  reg any_nan;
  reg mag_ge;
  reg mag_eq;
  reg flushed;
  reg ord_ge;
  always @* begin
    fa = flush(op_a);
    fb = flush(op_b);
    flushed = is_denorm(op_a) || is_denorm(op_b);
    any_nan = is_nan(op_a) || is_nan(op_b);
    a_zero = (fa[30:0] == 31'h0);
    b_zero = (fb[30:0] == 31'h0);
    mag_ge = (fa[30:0] >= fb[30:0]);
    mag_eq = (fa[30:0] == fb[30:0]);
    if (a_zero && b_zero) begin
      ord_ge = 1'b1;
    end else if (fa[31] != fb[31]) begin
      ord_ge = !fa[31];
    end else if (!fa[31]) begin
      ord_ge = mag_ge;
    end else begin
      ord_ge = !mag_ge || mag_eq;
    end
    ge = ord_ge && !any_nan;
    eq_flags = `FLAGS_RESET;
    // quiet nan stays silent for equality, signalling nan raises invalid
    if (is_snan(op_a) || is_snan(op_b)) begin
      eq_flags[`FLAG_INVALID] = 1'b1;
    end
    eq_flags[`FLAG_FLUSHED] = flushed;
    eq_flags_any = |eq_flags;
    ge_flags = `FLAGS_RESET;
    ge_flags[`FLAG_INVALID] = any_nan;
    ge_flags[`FLAG_FLUSHED] = flushed;
  end
endmodule // fp_cmp_core

// File: verilog/fp_compare_ge_and_eq_flags.v
// Purpose: compare unit slice for the equality flag query and ge compare
// Assumes: operands and guard come registered from the issue pipeline
// Notes: one-cycle latency; status-word flag sticky bits live here
`timescale 1ns/100ps
`include "fp_compare_map.vh"
module fp_compare_ge_and_eq_flags (
  input wire clk,
  input wire rstn,
  input wire issue_valid,
  input wire [7:0] opcode,
  input wire [2:0] issue_slot,
  input wire [31:0] first_source_register,
  input wire [31:0] second_source_register,
  input wire guard_present,
  input wire [31:0] guard_value,
  input wire [4:0] dest_index_in,
  input wire [`FLAG_W-1:0] other_flag_set,
  input wire flags_write,
  input wire [`FLAG_W-1:0] flags_write_data,
  output reg dest_write,
  output reg [4:0] dest_index,
  output reg [31:0] dest_data,
  output reg [`FLAG_W-1:0] processor_status_word,
  output wire input_flushed_zero_flag,
  output wire invalid_operation_flag
);
  // ************************************************************
  // decode helpers
  // ************************************************************
  // flag query only counts when issued in its own slot
  function op_is_flag_query;
    input [7:0] code;
    input [2:0] slot;
    begin
      op_is_flag_query = (code == `OPC_EQL_FLAGS) &&
                         (slot == `ISSUE_SLOT_EQL_FLAGS);
    end
  endfunction

  // ge compare is taken in any slot
  function op_is_ge_compare;
    input [7:0] code;
    begin
      op_is_ge_compare = (code == `OPC_GEQ);
    end
  endfunction

  // missing guard acts as a true guard
  function guard_passes;
    input present;
    input lsb;
    begin
      guard_passes = !present || lsb;
    end
  endfunction

  // ************************************************************
  // issue decode and guard
  // ************************************************************
  wire is_eqf;
  wire is_geq;
  wire guard_ok;
  wire eqf_taken;
  wire geq_taken;
  assign is_eqf = issue_valid && op_is_flag_query(opcode, issue_slot);
  assign is_geq = issue_valid && op_is_ge_compare(opcode);
  assign guard_ok = guard_passes(guard_present, guard_value[0]);
  // the two opcodes differ, so at most one is taken
  assign eqf_taken = is_eqf && guard_ok;
  assign geq_taken = is_geq && guard_ok;

  // ************************************************************
  // compare core
  // ************************************************************
  wire ge;
  wire [`FLAG_W-1:0] eq_flags;
  wire [`FLAG_W-1:0] ge_flags;
  fp_cmp_core u_core (
    .op_a(first_source_register),
    .op_b(second_source_register),
    .ge(ge),
    .eq_flags_any(),
    .eq_flags(eq_flags),
    .ge_flags(ge_flags)
  );

  // ************************************************************
  // result words
  // ************************************************************
  // flag vector and boolean are zero-extended to the register width
  wire [31:0] eqf_word;
  wire [31:0] geq_word;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_word
      if (gi < `FLAG_W) begin : g_flag_bit
        assign eqf_word[gi] = eq_flags[gi];
      end else begin : g_flag_pad
        assign eqf_word[gi] = 1'b0;
      end
      if (gi == 0) begin : g_ge_bit
        assign geq_word[gi] = ge;
      end else begin : g_ge_pad
        assign geq_word[gi] = 1'b0;
      end
    end
  endgenerate

  // ************************************************************
  // result select
  // ************************************************************
  localparam SEL_NONE = 2'b00;
  localparam SEL_EQF = 2'b01;
  localparam SEL_GEQ = 2'b10;
  reg [1:0] result_sel;
  reg dest_write_d;
  reg [4:0] dest_index_d;
  reg [31:0] dest_data_d;

  // refused ops select nothing and leave the old result in place
  always @* begin
    result_sel = SEL_NONE;
    if (eqf_taken) begin
      result_sel = SEL_EQF;
    end else if (geq_taken) begin
      result_sel = SEL_GEQ;
    end
  end

  always @* begin
    dest_write_d = 1'b0;
    dest_index_d = dest_index;
    dest_data_d = dest_data;
    case (result_sel)
      SEL_EQF: begin
        dest_write_d = 1'b1;
        dest_index_d = dest_index_in;
        dest_data_d = eqf_word;
      end
      SEL_GEQ: begin
        dest_write_d = 1'b1;
        dest_index_d = dest_index_in;
        dest_data_d = geq_word;
      end
      default: begin
        dest_write_d = 1'b0;
        dest_index_d = dest_index;
        dest_data_d = dest_data;
      end
    endcase
  end

  // ************************************************************
  // destination registers
  // ************************************************************
  // strobe stands one cycle after the issue edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dest_write <= 1'b0;
    end else begin
      dest_write <= dest_write_d;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dest_index <= `DEST_INDEX_RESET;
    end else begin
      dest_index <= dest_index_d;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dest_data <= `DEST_RESET;
    end else begin
      dest_data <= dest_data_d;
    end
  end

  // ************************************************************
  // sticky status-word flags
  // ************************************************************
  wire [`FLAG_W-1:0] flags_base;
  wire [`FLAG_W-1:0] flags_d;
  // explicit write replaces the base, same-cycle sets still land
  assign flags_base = flags_write ? flags_write_data : processor_status_word;

  // flag query contributes nothing here
  generate
    for (gi = 0; gi < `FLAG_W; gi = gi + 1) begin : g_flag
      wire from_ge;
      wire from_other;
      assign from_ge = geq_taken & ge_flags[gi];
      assign from_other = other_flag_set[gi];
      assign flags_d[gi] = flags_base[gi] | from_ge | from_other;
    end
  endgenerate

  // same edge as the destination write
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      processor_status_word <= `FLAGS_RESET;
    end else begin
      processor_status_word <= flags_d;
    end
  end

  // ************************************************************
  // flag views
  // ************************************************************
  assign input_flushed_zero_flag = processor_status_word[`FLAG_FLUSHED];
  assign invalid_operation_flag = processor_status_word[`FLAG_INVALID];
endmodule // fp_compare_ge_and_eq_flags

// File: sim/fp_cmp_properties.sv
// Purpose: port checks for the compare slice
// Assumes: one op issued per cycle
// Notes: bound to the top module below
`timescale 1ns/100ps
module fp_cmp_properties (
  input clk,
  input rstn,
  input issue_valid,
  input [7:0] opcode,
  input [2:0] issue_slot,
  input [31:0] first_source_register,
  input guard_present,
  input [31:0] guard_value,
  input [5:0] other_flag_set,
  input flags_write,
  input dest_write,
  input [5:0] processor_status_word,
  input input_flushed_zero_flag,
  input invalid_operation_flag
);
  wire gok = !guard_present || guard_value[0];
  wire ge_op = issue_valid && opcode == 8'h92 && gok;
  wire acc = ge_op || issue_valid && opcode == 8'h95 && issue_slot == 3'h3 && gok;
  wire quiet = !flags_write && other_flag_set == 6'h00;
  wire [5:0] psw = processor_status_word;
  wire [31:0] a = first_source_register;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_ge_nan;
    ge_op && &a[30:23] && |a[22:0];
  endsequence
  a_issue_answers: assert property (acc |=> dest_write)
    else $error("no result after issue");
  a_refused_silent: assert property (!acc |=> !dest_write)
    else $error("result without accepted issue");
  a_flags_sticky: assert property (!flags_write |=> (psw & $past(psw)) == $past(psw))
    else $error("flag cleared without write");
  a_sets_merge: assert property (1 |=> (psw & $past(other_flag_set)) == $past(other_flag_set))
    else $error("simultaneous set lost");
  a_eq_no_flags: assert property (issue_valid && opcode == 8'h95 && quiet |=> $stable(psw))
    else $error("flag query changed flags");
  a_guard_no_flags: assert property (issue_valid && opcode == 8'h92 && !gok && quiet |=> $stable(psw))
    else $error("guarded compare changed flags");
  a_nan_invalid: assert property (s_ge_nan |=> invalid_operation_flag && dest_write)
    else $error("nan compare without invalid flag");
  a_flush_flag: assert property (ge_op && a[30:23] == 8'h00 && |a[22:0] |=> input_flushed_zero_flag)
    else $error("denormal without flush flag");
endmodule // fp_cmp_properties
bind fp_compare_ge_and_eq_flags fp_cmp_properties chk_u (.clk, .rstn, .issue_valid, .opcode,
  .issue_slot, .first_source_register, .guard_present, .guard_value, .other_flag_set,
  .flags_write, .dest_write, .processor_status_word, .input_flushed_zero_flag,
  .invalid_operation_flag);

// File: sim/issue_port.sv
// Purpose: issue pipeline stand-in
// Assumes: one packed issue word per cycle
// Notes: fields are split out at the bench
`timescale 1ns/100ps
module issue_port (
  output logic [95:0] issue_bus
);
  initial issue_bus = 96'h0;
  task put(input logic [95:0] v);
    issue_bus <= v;
  endtask
endmodule // issue_port

// File: sim/fp_compare_ge_and_eq_flags_tb.sv
// Purpose: random self-check of the compare slice
// Assumes: one issue word per cycle, checked at negedge
// Notes: special values drawn from a small table
`timescale 1ns/100ps
module fp_compare_ge_and_eq_flags_tb;
  logic clk = 0, rstn = 0, dw, e_dw = 0;
  logic [95:0] w, v;
  logic [4:0] di, e_di = 0;
  logic [31:0] dd, e_dd = 0, a, b, c;
  logic [5:0] psw, e_sw = 0;
  logic [15:0] r = 16'h595b;
  int bad_count = 0, total_checks = 0;
  logic [43:0] exp_q[$];
  logic [43:0] e;
  logic flush_o, inval_o;
  logic [31:0] tbl [8] = '{32'h40400000, 32'h3f800000, 32'h0, 32'h7fffffff, 32'h00400000,
    32'h7f800000, 32'hff800000, 32'h7f800001};
  issue_port src_u (.issue_bus(w));
  fp_compare_ge_and_eq_flags dut_u (.clk(clk), .rstn(rstn), .issue_valid(w[95]),
    .opcode(w[94:87]), .issue_slot(w[86:84]), .first_source_register(w[83:52]),
    .second_source_register(w[51:20]), .guard_present(w[19]), .guard_value({w[83:53], w[18]}),
    .dest_index_in(w[17:13]), .other_flag_set(w[12:7]), .flags_write(w[6]),
    .flags_write_data(w[5:0]), .dest_write(dw), .dest_index(di), .dest_data(dd),
    .processor_status_word(psw), .input_flushed_zero_flag(flush_o),
    .invalid_operation_flag(inval_o));
  initial forever #4 clk = ~clk;
  function logic [31:0] rnd();
    r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    rnd[15:0] = r;
    r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    rnd[31:16] = r;
  endfunction
  function logic den(input logic [31:0] x);
    return x[30:23] == 8'h0 && x[22:0] != 0;
  endfunction
  function logic nan(input logic [31:0] x);
    return &x[30:23] && |x[22:0];
  endfunction
  function logic [31:0] key(input logic [31:0] x);
    return x[30:23] == 8'h0 ? 32'h80000000 : x[31] ? ~x : x | 32'h80000000;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk_flags(input logic [5:0] g6, input logic [5:0] e6);
    chk({26'h0, g6}, {26'h0, e6});
  endtask
  task model(input logic [95:0] x);
    logic acc, eq;
    logic [5:0] f;
    a = x[83:52];
    b = x[51:20];
    eq = x[94:87] == 8'h95;
    acc = x[95] && (eq && x[86:84] == 3'h3 || x[94:87] == 8'h92) && (!x[19] || x[18]);
    f = {den(a) | den(b), eq ? nan(a) & !a[22] | nan(b) & !b[22] : nan(a) | nan(b), 4'h0};
    e_dw = acc;
    if (acc) begin
      e_di = x[17:13];
      e_dd = eq ? {26'h0, f} : {31'h0, !nan(a) && !nan(b) && key(a) >= key(b)};
    end
    e_sw = (x[6] ? x[5:0] : e_sw) | x[12:7] | (acc && !eq ? f : 6'h0);
    exp_q.push_back({e_dw, e_di, e_dd, e_sw});
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    // idle word seen at the first edge after reset
    exp_q.push_back(44'h0);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i <= 3000; i++) begin
      @(posedge clk);
      a = rnd();
      b = rnd();
      c = rnd();
      v = {c[0] | c[1], a[1:0] == 2'h3 ? 8'h93 : a[1] ? 8'h92 : 8'h95, c[4] ? c[7:5] : 3'h3,
        a[31] ? a : tbl[a[4:2]], b[31] ? b : tbl[b[4:2]], c[8], c[9] | c[10], c[15:11],
        c[16] & c[17] ? c[23:18] : 6'h0, c[24] & c[25] & c[26], c[31:27], c[2]};
      if (i == 3000) begin
        v = 96'h0;
      end
      src_u.put(v);
      model(v);
      @(negedge clk);
      // outputs now answer the word sampled at this cycle's rising edge
      e = exp_q.pop_front();
      chk({31'h0, dw}, {31'h0, e[43]});
      chk(dd, e[37:6]);
      chk({27'h0, di}, {27'h0, e[42:38]});
      chk_flags(psw, e[5:0]);
      chk_flags({flush_o, inval_o, 4'h0}, {e[5:4], 4'h0});
    end
    end_of_test;
  end
endmodule // fp_compare_ge_and_eq_flags_tb
